// [ddio_top.sv]
// operator switch inputs, setpoint stepping, ramp and alarm outputs with AXI4-Lite registers
// Contract
// RULE_01: mode input picks primary or secondary scaling format, defaults leader and follower.
// RULE_02: primary mode uses setpoint 1 when select open, setpoint 2 when closed.
// RULE_03: secondary mode uses setpoint 3 when select open, setpoint 4 when closed.
// RULE_04: ramp-hold freezes acceleration and deceleration until released.
// RULE_05: fast stop zeroes speed at once, overriding ramp-hold.
// RULE_06: keypad lock rejects keypad parameter writes; mask picks protected setpoints.
// RULE_07: keypad viewing of variables keeps working under lock.
// RULE_08: serial reads always allowed; serial writes only with remote input closed.
// RULE_09: each up closure adds one unit, then one more every half second held.
// RULE_10: each down closure subtracts one unit, then one more every half second held.
// RULE_11: zero-speed output from ramp alone or ramp and feedback, by config.
// RULE_12: high alarm low when feedback at or above high limit.
// RULE_13: low alarm low when feedback at or below low limit.
// RULE_14: ramped error alarm low when ramp minus feedback reaches the band.
// RULE_15: scaled error alarm same, using scaled reference and its own band.
// RULE_16: analog output routable to any monitor variable or parameter.
// RULE_17: analog input may replace one of three frequency inputs or four setpoints.
// RULE_18: current limit lights limit indicator and reports status code 7.
// RULE_19: under current limit speed droops with load at an adjustable rate.
// RULE_20: current limit disabled when scaling format is direct, value 0.
// RULE_21: fast-stop opening is latched; speed zeroes without deceleration ramp.
// RULE_22: run entered only with ramped-stop and fast-stop inputs both closed.
// RULE_23: switch inputs synchronised and debounced; one closure gives one event.
// RULE_24: setpoint steps clamp to range and skip lock-protected setpoints.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
module ddio_top
  import ddio_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
  parameter int unsigned REP_CYC = REPEAT_CYC,
  parameter int unsigned TICK_CYC = RAMP_TICK_CYC,
  parameter logic [ddio_pkg::DW-1:0] SP_MAX = ddio_pkg::SP_MAX_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [ddio_pkg::NPIN-1:0] SWITCH_I,
  input wire logic [ddio_pkg::DW-1:0] FEEDBACK_I,
  input wire logic [ddio_pkg::DW-1:0] ANALOG_IN_I,
  input wire logic KEY_WR_I,
  input wire logic [ddio_pkg::IW-1:0] KEY_IDX_I,
  input wire logic [ddio_pkg::DW-1:0] KEY_DATA_I,
  input wire logic [ddio_pkg::IW-1:0] KEY_VIEW_IDX_I,
  input wire logic SER_WR_I,
  input wire logic [ddio_pkg::IW-1:0] SER_IDX_I,
  input wire logic [ddio_pkg::DW-1:0] SER_DATA_I,
  input wire logic [ddio_pkg::IW-1:0] SER_VIEW_IDX_I,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [ddio_pkg::AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [ddio_pkg::AW-1:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic [ddio_pkg::DW-1:0] SPEED_O,
  output logic [1:0] SCALE_FMT_O,
  output logic RUN_LED_O,
  output logic PRESET_LED_O,
  output logic LIMIT_LED_O,
  output logic ZERO_SPEED_N_O,
  output logic HIGH_ALARM_N_O,
  output logic LOW_ALARM_N_O,
  output logic RAMP_ERR_N_O,
  output logic SCALE_ERR_N_O,
  output logic [ddio_pkg::DW-1:0] ANALOG_OUT_O,
  output logic [1:0] FREQ_SUB_O,
  output logic KEY_REJ_O,
  output logic SER_REJ_O,
  output logic [ddio_pkg::DW-1:0] KEY_VIEW_O,
  output logic [ddio_pkg::DW-1:0] SER_VIEW_O
);
  import ddio_pkg::*;

  logic [NPIN-1:0] sw;
  logic [DW-1:0] par_r [NPAR];
  logic [DW-1:0] acfg_r;
  logic [DW-1:0] ramp_r;
  logic [DW-1:0] droop_r;
  logic [DW-1:0] code_r;
  logic run_r;
  logic fstop_lat_r;
  logic lim_act_r;
  logic up_prev_r;
  logic dn_prev_r;
  logic [31:0] rep_cnt_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [1:0] act_idx;
  logic [DW-1:0] sp_act;
  logic [1:0] fmt;
  logic step_up;
  logic step_dn;
  logic rep_done;
  logic aw_hold_r;
  logic w_hold_r;
  logic [AW-1:0] aw_addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic aw_ok;
  logic key_ok;
  logic ser_ok;
  logic [2:0] in_sub;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      ddio_debounce #(.CYC(DEB_CYC)) u_deb (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .pin_i(SWITCH_I[gi]),
        .level_o(sw[gi])
      );
    end
  endgenerate

  function automatic logic [DW-1:0] abs_diff(input logic [DW-1:0] a, input logic [DW-1:0] b);
    abs_diff = (a >= b) ? a - b : b - a;
  endfunction

  function automatic logic addr_ok(input logic [AW-1:0] a);
    addr_ok = (a[AW-1:IW+2] == '0) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // one view mux serves AXI, keypad and serial reads, never gated by lock
  function automatic logic [DW-1:0] view(input logic [IW-1:0] i);
    if (i < IDX_ANALOG_CFG) begin
      view = par_r[i];
    end else begin
      unique case (i)
        IDX_ANALOG_CFG: view = acfg_r;
        IDX_STATUS: view = {6'h0, fmt, lim_act_r, fstop_lat_r, run_r, sw[P_CLIM],
                            ~HIGH_ALARM_N_O, ~LOW_ALARM_N_O, ~RAMP_ERR_N_O, ~SCALE_ERR_N_O};
        IDX_STATUS_CODE: view = code_r;
        IDX_RAMP_REF: view = ramp_r;
        IDX_SPEED: view = SPEED_O;
        default: view = FEEDBACK_I;
      endcase
    end
  endfunction

  assign fmt = sw[P_MODE] ? par_r[IDX_CONFIG][CFG_SEC_FMT_LSB +: 2]
                          : par_r[IDX_CONFIG][CFG_PRI_FMT_LSB +: 2]; // RULE_01
  assign act_idx = sw[P_MODE] ? {1'b1, sw[P_SP2]} : {1'b0, sw[P_SP1]}; // RULE_02 RULE_03
  assign in_sub = acfg_r[ACFG_IN_SUB_LSB +: 3];
  // an analog-substituted setpoint takes the live analog word
  assign sp_act = (in_sub == {1'b0, act_idx} + 3'h1) ? ANALOG_IN_I
                                                     : par_r[act_idx]; // RULE_17
  assign rep_done = rep_cnt_r >= REP_CYC - 1;
  assign step_up = sw[P_UP] && !sw[P_DN] && (!up_prev_r || rep_done); // RULE_09
  assign step_dn = sw[P_DN] && !sw[P_UP] && (!dn_prev_r || rep_done); // RULE_10
  assign tick = tick_cnt_r >= TICK_CYC - 1;
  assign do_wr = aw_hold_r && w_hold_r && !S_AXI_BVALID;
  assign aw_ok = addr_ok(aw_addr_r) && aw_addr_r[IW+1:2] <= IDX_ANALOG_CFG;
  assign key_ok = KEY_IDX_I < IDX_ANALOG_CFG &&
                  !(sw[P_LOCK] && (KEY_IDX_I >= IDX_HIGH_LIMIT ||
                                   par_r[IDX_PROTECT_MASK][KEY_IDX_I[1:0]])); // RULE_06
  assign ser_ok = sw[P_REMOTE] && SER_IDX_I <= IDX_ANALOG_CFG; // RULE_08

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      up_prev_r <= 1'b0;
      dn_prev_r <= 1'b0;
      rep_cnt_r <= 32'h0;
    end else begin
      up_prev_r <= sw[P_UP];
      dn_prev_r <= sw[P_DN];
      rep_cnt_r <= (step_up || step_dn || !(sw[P_UP] ^ sw[P_DN])) ? 32'h0 : rep_cnt_r + 32'h1;
    end
  end

  // priority: software over serial over keypad over scroll keys
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < NPAR; i++) begin
        par_r[i] <= '0;
      end
      par_r[IDX_HIGH_LIMIT] <= HIGH_LIMIT_RST;
      par_r[IDX_RAMP_BAND] <= BAND_RST;
      par_r[IDX_SCALED_BAND] <= BAND_RST;
      par_r[IDX_CONFIG] <= CONFIG_RST;
      acfg_r <= '0;
    end else if (do_wr && aw_ok) begin
      if (aw_addr_r[IW+1:2] == IDX_ANALOG_CFG) begin
        acfg_r <= merge(acfg_r, wdata_r, wstrb_r);
      end else begin
        par_r[aw_addr_r[IW+1:2]] <= merge(par_r[aw_addr_r[IW+1:2]], wdata_r, wstrb_r);
      end
    end else if (SER_WR_I && ser_ok) begin
      if (SER_IDX_I == IDX_ANALOG_CFG) begin
        acfg_r <= SER_DATA_I; // RULE_16
      end else begin
        par_r[SER_IDX_I] <= SER_DATA_I;
      end
    end else if (KEY_WR_I && key_ok) begin
      par_r[KEY_IDX_I] <= KEY_DATA_I;
    end else if ((step_up || step_dn) && !(sw[P_LOCK] && par_r[IDX_PROTECT_MASK][act_idx])
                 && in_sub != {1'b0, act_idx} + 3'h1) begin
      if (step_up && par_r[act_idx] < SP_MAX) begin
        par_r[act_idx] <= par_r[act_idx] + 16'h1; // RULE_09 RULE_24
      end else if (step_dn && par_r[act_idx] != '0) begin
        par_r[act_idx] <= par_r[act_idx] - 16'h1; // RULE_10 RULE_24
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      KEY_REJ_O <= 1'b0;
      SER_REJ_O <= 1'b0;
      KEY_VIEW_O <= '0;
      SER_VIEW_O <= '0;
    end else begin
      KEY_REJ_O <= KEY_WR_I && !key_ok;
      SER_REJ_O <= SER_WR_I && !ser_ok;
      KEY_VIEW_O <= view(KEY_VIEW_IDX_I); // RULE_07
      SER_VIEW_O <= view(SER_VIEW_IDX_I); // RULE_08
    end
  end

  // fast-stop opening latches and cancels run; run needs both stops closed
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      run_r <= 1'b0;
      fstop_lat_r <= 1'b1;
    end else if (!sw[P_FSTOP]) begin
      run_r <= 1'b0;
      fstop_lat_r <= 1'b1; // RULE_21
    end else if (!sw[P_RSTOP]) begin
      run_r <= 1'b0;
    end else if (sw[P_RUN]) begin
      run_r <= 1'b1; // RULE_22
      fstop_lat_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // ramp moves one unit per tick toward the target; hold freezes it
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || fstop_lat_r) begin
      ramp_r <= '0; // RULE_05 RULE_21
    end else if (sw[P_HOLD]) begin
      ramp_r <= ramp_r; // RULE_04
    end else if (tick) begin
      if (ramp_r < (run_r ? sp_act : '0)) begin
        ramp_r <= ramp_r + 16'h1;
      end else if (ramp_r > (run_r ? sp_act : '0)) begin
        ramp_r <= ramp_r - 16'h1;
      end
    end
  end

  // droop grows while limiting, up to the ramp seen on each tick; a falling ramp can drop below it and wrap speed
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I || !lim_act_r) begin
      droop_r <= '0;
    end else if (tick) begin
      droop_r <= (ramp_r - droop_r > {8'h0, par_r[IDX_CONFIG][CFG_DROOP_LSB +: 8]})
                 ? droop_r + {8'h0, par_r[IDX_CONFIG][CFG_DROOP_LSB +: 8]} : ramp_r; // RULE_19
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      lim_act_r <= 1'b0;
      code_r <= CODE_STOPPED;
      SPEED_O <= '0;
      SCALE_FMT_O <= FMT_DIRECT;
    end else begin
      lim_act_r <= sw[P_CLIM] && run_r && fmt != FMT_DIRECT; // RULE_20
      code_r <= lim_act_r ? CODE_CUR_LIMIT : (run_r ? CODE_RUNNING : CODE_STOPPED); // RULE_18
      SPEED_O <= fstop_lat_r ? '0 : ramp_r - droop_r; // RULE_05
      SCALE_FMT_O <= fmt; // RULE_01
    end
  end

  // open-collector alarms: low is active
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      HIGH_ALARM_N_O <= 1'b1;
      LOW_ALARM_N_O <= 1'b1;
      RAMP_ERR_N_O <= 1'b1;
      SCALE_ERR_N_O <= 1'b1;
      ZERO_SPEED_N_O <= 1'b1;
      RUN_LED_O <= 1'b0;
      PRESET_LED_O <= 1'b0;
      LIMIT_LED_O <= 1'b0;
      ANALOG_OUT_O <= '0;
      FREQ_SUB_O <= 2'h0;
    end else begin
      HIGH_ALARM_N_O <= !(FEEDBACK_I >= par_r[IDX_HIGH_LIMIT]); // RULE_12
      LOW_ALARM_N_O <= !(FEEDBACK_I <= par_r[IDX_LOW_LIMIT]); // RULE_13
      RAMP_ERR_N_O <= !(abs_diff(ramp_r, FEEDBACK_I) >= par_r[IDX_RAMP_BAND]); // RULE_14
      SCALE_ERR_N_O <= !(abs_diff(sp_act, FEEDBACK_I) >= par_r[IDX_SCALED_BAND]); // RULE_15
      ZERO_SPEED_N_O <= !(ramp_r == '0 &&
                          (!par_r[IDX_CONFIG][CFG_ZERO_SRC_BIT] || FEEDBACK_I == '0)); // RULE_11
      RUN_LED_O <= run_r;
      PRESET_LED_O <= act_idx[0];
      LIMIT_LED_O <= lim_act_r || !HIGH_ALARM_N_O || !LOW_ALARM_N_O; // RULE_18
      ANALOG_OUT_O <= view(acfg_r[ACFG_OUT_SEL_LSB +: IW]); // RULE_16
      // codes 5..7 name frequency inputs 1..3, which are the low two bits
      FREQ_SUB_O <= (in_sub > 3'h4) ? in_sub[1:0] : 2'h0; // RULE_17
    end
  end

  // AXI4-Lite write: address and data taken in either order, answered together
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= aw_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= addr_ok(S_AXI_ARADDR) ? {16'h0, view(S_AXI_ARADDR[IW+1:2])} : 32'h0;
      S_AXI_RRESP <= addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  sequence s_fstop_open;
    !sw[P_FSTOP] ##1 sw[P_FSTOP];
  endsequence
  property p_fstop_latch;
    @(posedge REF_CLK_I) disable iff (RST_I) s_fstop_open |-> fstop_lat_r && !run_r;
  endproperty
  a_fstop_latch: assert property (p_fstop_latch) else $error("fast stop not latched"); // RULE_21
  property p_fstop_zero;
    @(posedge REF_CLK_I) disable iff (RST_I) fstop_lat_r |=> SPEED_O == '0 && ramp_r == '0;
  endproperty
  a_fstop_zero: assert property (p_fstop_zero) else $error("speed not zero in fast stop"); // RULE_05
  property p_hold;
    @(posedge REF_CLK_I) disable iff (RST_I) sw[P_HOLD] && !fstop_lat_r |=> $stable(ramp_r);
  endproperty
  a_hold: assert property (p_hold) else $error("ramp moved under hold"); // RULE_04
  property p_high;
    @(posedge REF_CLK_I) disable iff (RST_I)
      FEEDBACK_I >= par_r[IDX_HIGH_LIMIT] |=> !HIGH_ALARM_N_O;
  endproperty
  a_high: assert property (p_high) else $error("high alarm missing"); // RULE_12
  property p_low;
    @(posedge REF_CLK_I) disable iff (RST_I) FEEDBACK_I > par_r[IDX_LOW_LIMIT] |=> LOW_ALARM_N_O;
  endproperty
  a_low: assert property (p_low) else $error("low alarm false"); // RULE_13
  property p_code7;
    @(posedge REF_CLK_I) disable iff (RST_I) lim_act_r |=> code_r == CODE_CUR_LIMIT && LIMIT_LED_O;
  endproperty
  a_code7: assert property (p_code7) else $error("limit status not shown"); // RULE_18
  property p_direct;
    @(posedge REF_CLK_I) disable iff (RST_I) fmt == FMT_DIRECT ##1 $stable(fmt) |-> !lim_act_r;
  endproperty
  a_direct: assert property (p_direct) else $error("limit active in direct format"); // RULE_20
  property p_ser_rej;
    @(posedge REF_CLK_I) disable iff (RST_I) SER_WR_I && !sw[P_REMOTE] |=> SER_REJ_O;
  endproperty
  a_ser_rej: assert property (p_ser_rej) else $error("serial write not refused"); // RULE_08
  property p_key_rej;
    @(posedge REF_CLK_I) disable iff (RST_I)
      KEY_WR_I && sw[P_LOCK] && KEY_IDX_I >= IDX_HIGH_LIMIT |=> KEY_REJ_O;
  endproperty
  a_key_rej: assert property (p_key_rej) else $error("locked keypad write taken"); // RULE_06
  property p_run;
    @(posedge REF_CLK_I) disable iff (RST_I) $rose(run_r) |-> $past(sw[P_FSTOP] && sw[P_RSTOP]);
  endproperty
  a_run: assert property (p_run) else $error("run entered with a stop open"); // RULE_22
endmodule

// [ddio_pkg.sv]
// constants, register map and timing for the discrete operator and alarm logic
package ddio_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned DEBOUNCE_MS = 5;
  localparam int unsigned REPEAT_MS = 500;
  localparam int unsigned RAMP_TICK_US = 100;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned REPEAT_CYC = CLK_HZ / 1000 * REPEAT_MS;
  localparam int unsigned RAMP_TICK_CYC = CLK_HZ / 1_000_000 * RAMP_TICK_US;
  localparam int unsigned DW = 16;
  localparam int unsigned IW = 4;
  localparam int unsigned AW = 8;
  localparam int unsigned NPAR = 10;
  // register indices, byte address is index times four
  localparam logic [IW-1:0] IDX_SP1 = 4'h0;
  localparam logic [IW-1:0] IDX_HIGH_LIMIT = 4'h4;
  localparam logic [IW-1:0] IDX_LOW_LIMIT = 4'h5;
  localparam logic [IW-1:0] IDX_RAMP_BAND = 4'h6;
  localparam logic [IW-1:0] IDX_SCALED_BAND = 4'h7;
  localparam logic [IW-1:0] IDX_PROTECT_MASK = 4'h8;
  localparam logic [IW-1:0] IDX_CONFIG = 4'h9;
  localparam logic [IW-1:0] IDX_ANALOG_CFG = 4'hA;
  localparam logic [IW-1:0] IDX_STATUS = 4'hB;
  localparam logic [IW-1:0] IDX_STATUS_CODE = 4'hC;
  localparam logic [IW-1:0] IDX_RAMP_REF = 4'hD;
  localparam logic [IW-1:0] IDX_SPEED = 4'hE;
  localparam logic [IW-1:0] IDX_FEEDBACK = 4'hF;
  // config register fields
  localparam int unsigned CFG_PRI_FMT_LSB = 0;
  localparam int unsigned CFG_SEC_FMT_LSB = 2;
  localparam int unsigned CFG_ZERO_SRC_BIT = 4;
  localparam int unsigned CFG_DROOP_LSB = 8;
  localparam int unsigned ACFG_IN_SUB_LSB = 0;
  localparam int unsigned ACFG_OUT_SEL_LSB = 4;
  localparam logic [1:0] FMT_DIRECT = 2'h0;
  localparam logic [1:0] FMT_LEADER = 2'h1;
  localparam logic [1:0] FMT_FOLLOWER = 2'h2;
  localparam logic [DW-1:0] CONFIG_RST = 16'h1009;
  localparam logic [DW-1:0] HIGH_LIMIT_RST = 16'hFFFF;
  localparam logic [DW-1:0] BAND_RST = 16'hFFFF;
  localparam logic [DW-1:0] SP_MAX_DEF = 16'h270F;
  localparam logic [DW-1:0] CODE_STOPPED = 16'h0000;
  localparam logic [DW-1:0] CODE_RUNNING = 16'h0001;
  localparam logic [DW-1:0] CODE_CUR_LIMIT = 16'h0007;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // pin vector positions of the debounced switch inputs
  localparam int unsigned NPIN = 12;
  localparam int unsigned P_MODE = 0;
  localparam int unsigned P_SP1 = 1;
  localparam int unsigned P_SP2 = 2;
  localparam int unsigned P_HOLD = 3;
  localparam int unsigned P_LOCK = 4;
  localparam int unsigned P_REMOTE = 5;
  localparam int unsigned P_UP = 6;
  localparam int unsigned P_DN = 7;
  localparam int unsigned P_RUN = 8;
  localparam int unsigned P_RSTOP = 9;
  localparam int unsigned P_FSTOP = 10;
  localparam int unsigned P_CLIM = 11;
endpackage

// [ddio_debounce.sv]
// two-flop synchroniser and stability debouncer for one switch input
module ddio_debounce #(
  parameter int unsigned CYC = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic sync1_r;
  logic sync2_r;
  logic [31:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  // bounce restarts the count, so one closure gives one clean edge
  always_ff @(posedge clk_i) begin
    if (rst_i || sync2_r == level_o) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (sync2_r != level_o && cnt_r >= CYC - 1) begin
      level_o <= sync2_r; // RULE_23
    end
  end

  property p_deb_hold;
    @(posedge clk_i) disable iff (rst_i)
      $changed(level_o) |-> $past(cnt_r) >= CYC - 1;
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("debounced level moved early"); // RULE_23
endmodule

// [ddio_panel_model.sv]
// operator switch panel and serial host driving the discrete inputs
module ddio_panel_model
  import ddio_pkg::*;
(
  input wire logic clk_i,
  output logic [NPIN-1:0] sw_o,
  output logic ser_wr_o,
  output logic [IW-1:0] ser_idx_o,
  output logic [DW-1:0] ser_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // both stop loops wired closed so a run closure can start the drive
  initial sw_o = NPIN'((1 << P_RSTOP) | (1 << P_FSTOP));
  initial ser_wr_o = 1'b0;
  initial ser_idx_o = '0;
  initial ser_data_o = '0;
  task automatic set_sw(input int p, input logic v);
    @(posedge clk_i);
    sw_o[p] <= v;
  endtask
  // data line is scrambled after the strobe so a late sample cannot match
  task automatic ser_write(input logic [IW-1:0] i, input logic [DW-1:0] v);
    @(posedge clk_i);
    ser_wr_o <= 1'b1;
    ser_idx_o <= i;
    ser_data_o <= v;
    @(posedge clk_i);
    ser_wr_o <= 1'b0;
    ser_data_o <= ~v;
  endtask
endmodule

// [tb_top.sv]
// testbench: AXI register access, switch, keypad and serial scenarios
module tb_top;
  import ddio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, aw = 0, wv = 0, br = 0, ar = 0, rr = 0, kw = 0;
  logic [AW-1:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [IW-1:0] ki = 0, kv = 0, sv = 0, si;
  logic [DW-1:0] kd = 0, fb = 0, spd, kvo, svo, sd, s, ao;
  logic [NPIN-1:0] sw;
  logic awr, wr, bv, arr, rv, rl, ll, hn, ln, ren, sen, krj, srj, swr, zn;
  logic [1:0] bresp, rresp, fmt, r, fsub;
  int num_errors = 0, checks = 0, cyc = 0;
  int fv[8] = '{100, 99, 50, 51, 30, 29, 25, 24};
  ddio_top #(.DEB_CYC(4), .REP_CYC(20), .TICK_CYC(2)) ddio_top_inst (
    .REF_CLK_I(clk), .RST_I(rst), .SWITCH_I(sw), .FEEDBACK_I(fb), .ANALOG_IN_I(16'h0000),
    .KEY_WR_I(kw), .KEY_IDX_I(ki), .KEY_DATA_I(kd), .KEY_VIEW_IDX_I(kv), .SER_WR_I(swr),
    .SER_IDX_I(si), .SER_DATA_I(sd), .SER_VIEW_IDX_I(sv), .S_AXI_AWVALID(aw),
    .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
    .SPEED_O(spd), .SCALE_FMT_O(fmt), .RUN_LED_O(rl), .PRESET_LED_O(), .LIMIT_LED_O(ll),
    .ZERO_SPEED_N_O(zn), .HIGH_ALARM_N_O(hn), .LOW_ALARM_N_O(ln), .RAMP_ERR_N_O(ren),
    .SCALE_ERR_N_O(sen), .ANALOG_OUT_O(ao), .FREQ_SUB_O(fsub), .KEY_REJ_O(krj),
    .SER_REJ_O(srj),
    .KEY_VIEW_O(kvo), .SER_VIEW_O(svo));
  ddio_panel_model ddio_panel_model_inst (.clk_i(clk), .sw_o(sw), .ser_wr_o(swr),
    .ser_idx_o(si), .ser_data_o(sd));
  always #2.5 clk = ~clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // the run needs well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ps(input int p, input logic v, input int n);
    ddio_panel_model_inst.set_sw(p, v);
    wt(n);
  endtask
  task automatic axw(input logic [7:0] a, input logic [15:0] v, output logic [1:0] rs);
    @(posedge clk);
    aw <= 1; wv <= 1; awa <= a; wd <= {16'h0000, v}; br <= 1;
    do begin
      @(posedge clk);
      if (awr) aw <= 0;
      if (wr) wv <= 0;
    end while (!bv);
    rs = bresp;
    br <= 0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    ar <= 1; ara <= a; rr <= 1;
    do begin
      @(posedge clk);
      if (arr) ar <= 0;
    end while (!rv);
    r = rresp;
    rr <= 0;
    chk(nm, rdat, e);
  endtask
  task automatic kwr(input logic [3:0] i, input logic [15:0] v);
    @(posedge clk);
    kw <= 1; ki <= i; kd <= v;
    @(posedge clk);
    kw <= 0; kd <= ~v;
    #1;
  endtask
  initial begin
    wt(2);
    rst <= 0;
    wt(10);
    rdchk("config_rst", 8'h24, 32'h1009);
    rdchk("unmapped", 8'h40, 0);
    chk("unmapped_resp", r, RESP_SLVERR);
    axw(8'h2C, 16'h0001, r);
    chk("ro_write", r, RESP_SLVERR);
    for (int i = 0; i < 4; i++) axw(8'(4 * i), 16'(10 * i + 10), r);
    for (int m = 0; m < 4; m++) begin
      ps(P_MODE, m[1], 0);
      ps(P_SP1, m[0], 0);
      ps(P_SP2, !m[0], 10);
      chk("fmt", fmt, m[1] ? FMT_FOLLOWER : FMT_LEADER);
      chk("preset", ddio_top_inst.PRESET_LED_O, m[1] ? !m[0] : m[0]);
    end
    ps(P_MODE, 0, 0);
    ps(P_SP1, 0, 10);
    $display("select test done");
    axw(8'h10, 100, r);
    axw(8'h14, 50, r);
    axw(8'h18, 25, r);
    axw(8'h1C, 20, r);
    foreach (fv[i]) begin
      fb <= DW'(fv[i]);
      wt(4);
      chk("high", hn, fv[i] < 100);
      chk("low", ln, fv[i] > 50);
      chk("ramp_err", ren, fv[i] < 25);
      chk("scaled_err", sen, fv[i] < 30);
    end
    chk("zero_ramp", zn, 0);
    axw(8'h24, 16'h1019, r);
    wt(2);
    chk("zero_fb", zn, 1);
    $display("alarm test done");
    ps(P_UP, 1, 50);
    ps(P_UP, 0, 10);
    rdchk("sp_up", 8'h00, 13);
    ps(P_DN, 1, 15);
    ps(P_DN, 0, 10);
    rdchk("sp_down", 8'h00, 12);
    axw(8'h00, 0, r);
    ps(P_DN, 1, 15);
    ps(P_DN, 0, 10);
    rdchk("sp_floor", 8'h00, 0);
    $display("scroll test done");
    axw(8'h20, 1, r);
    ps(P_LOCK, 1, 10);
    kwr(0, 5);
    chk("key_locked", krj, 1);
    kwr(1, 7);
    chk("key_free", krj, 0);
    rdchk("sp2_key", 8'h04, 7);
    kv <= 1;
    wt(3);
    chk("key_view", kvo, 7);
    ps(P_UP, 1, 15);
    ps(P_UP, 0, 10);
    rdchk("sp1_masked", 8'h00, 0);
    ps(P_LOCK, 0, 10);
    sv <= 1;
    ddio_panel_model_inst.ser_write(1, 9);
    #1;
    chk("ser_local", srj, 1);
    chk("ser_view", svo, 7);
    ps(P_REMOTE, 1, 10);
    ddio_panel_model_inst.ser_write(1, 9);
    #1;
    chk("ser_remote", srj, 0);
    rdchk("sp2_ser", 8'h04, 9);
    $display("access test done");
    axw(8'h00, 50, r);
    ps(P_RUN, 1, 10);
    ps(P_RUN, 0, 20);
    chk("run", rl, 1);
    ps(P_HOLD, 1, 10);
    s = spd;
    wt(20);
    chk("hold", spd, s);
    ps(P_FSTOP, 0, 10);
    chk("fast_stop", spd, 0);
    ps(P_FSTOP, 1, 20);
    chk("stop_latched", rl, 0);
    fb <= 75;
    ps(P_HOLD, 0, 0);
    ps(P_RUN, 1, 10);
    ps(P_RUN, 0, 0);
    ps(P_CLIM, 1, 10);
    chk("limit_led", ll, 1);
    rdchk("limit_code", 8'h30, 7);
    axw(8'h24, 16'h1008, r);
    wt(4);
    chk("direct_nolimit", ll, 0);
    axw(8'h28, 16'h0016, r);
    wt(2);
    chk("freq_sub", fsub, 2);
    chk("analog_out", ao, 9);
    $display("run test done");
    close_out();
  end
endmodule
